/* File: rtl/cod_regs.vh */
// constants for the byte move and exchange unit
`ifndef COD_REGS_VH
`define COD_REGS_VH
// operand kinds
`define COD_K_REG 4'h0
`define COD_K_SADDR 4'h1
`define COD_K_SFR 4'h2
`define COD_K_ABS 4'h3
`define COD_K_PSW 4'h4
`define COD_K_DE 4'h5
`define COD_K_HL 4'h6
`define COD_K_HLBYTE 4'h7
`define COD_K_HLB 4'h8
`define COD_K_HLC 4'h9
// byte register absolute indices
`define COD_R_X 3'h0
`define COD_R_A 3'h1
`define COD_R_C 3'h2
`define COD_R_B 3'h3
`define COD_R_E 3'h4
`define COD_R_D 3'h5
`define COD_R_L 3'h6
`define COD_R_H 3'h7
// register pair indices
`define COD_RP_AX 2'h0
`define COD_RP_BC 2'h1
`define COD_RP_DE 2'h2
`define COD_RP_HL 2'h3
// address map
`define COD_SADDR_LO_BASE 16'hFE00
`define COD_SADDR_HI_BASE 16'hFF00
`define COD_SADDR_WRAP 8'h20
`define COD_SFR_BASE 16'hFF00
`define COD_SFR_HOLE_LO 16'hFFD0
`define COD_SFR_HOLE_HI 16'hFFDF
`define COD_CALL11_BASE 16'h0800
`define COD_TABLE5_BASE 16'h0040
// program status word fields and reset value
`define COD_PSW_IE 7
`define COD_PSW_Z 6
`define COD_PSW_RBS1 5
`define COD_PSW_AC 4
`define COD_PSW_RBS0 3
`define COD_PSW_CY 0
`define COD_PSW_RST 8'h00
// instruction clock counts
`define COD_CK_REG 4'h2
`define COD_CK_REGI 4'h4
`define COD_CK_SHORT1 4'h4
`define COD_CK_SHORT2 4'h5
`define COD_CK_SHORTX2 4'h6
`define COD_CK_IMMS1 4'h6
`define COD_CK_IMMS2 4'h7
`define COD_CK_HLR1 4'h6
`define COD_CK_HLR2 4'h7
`define COD_CK_LONG1 4'h8
`define COD_CK_LONG2 4'h9
`define COD_CK_LONGX2 4'hA
// encoding lengths
`define COD_B1 2'h1
`define COD_B2 2'h2
`define COD_B3 2'h3
`endif

/* File: rtl/cod_operand_resolve.v */
// operand address, legality and clock count resolution
`default_nettype none
`include "cod_regs.vh"
module cod_operand_resolve (
  // operation form
  input wire op_xch,
  input wire op_dir,
  input wire op_imm,
  input wire [3:0] op_kind,
  input wire [2:0] op_reg,
  input wire [7:0] op_imm8,
  input wire [15:0] op_abs16,
  // register values used for indirect forms
  input wire [15:0] hl_val,
  input wire [15:0] de_val,
  input wire [7:0] b_val,
  input wire [7:0] c_val,
  // resolution
  output reg [15:0] res_addr,
  output reg res_mem,
  output reg res_sfr,
  output reg res_legal,
  output reg res_has_ck1,
  output reg [3:0] res_ck1,
  output reg [3:0] res_ck2,
  output reg [1:0] res_bytes
);
  reg [15:0] sadr;
  reg [15:0] sfra;
  always @*
  begin
    // short direct window folds the low 20h offsets onto the top page
    if (op_imm8 < `COD_SADDR_WRAP) // RQ3
      sadr = `COD_SADDR_HI_BASE | {8'h00, op_imm8};
    else
      sadr = `COD_SADDR_LO_BASE | {8'h00, op_imm8};
    sfra = `COD_SFR_BASE | {8'h00, op_imm8};
    res_addr = 16'h0000;
    res_mem = 1'b0;
    res_sfr = 1'b0;
    res_legal = 1'b1;
    res_has_ck1 = 1'b1;
    res_ck1 = `COD_CK_REG;
    res_ck2 = `COD_CK_REG;
    res_bytes = `COD_B1;
    case (op_kind)
      `COD_K_REG:
      begin
        if (op_imm)
        begin
          res_ck1 = `COD_CK_REGI;
          res_bytes = `COD_B2;
          res_legal = ~op_xch;
        end
        else
          res_legal = ~(op_dir & ~op_xch & (op_reg == `COD_R_A));
      end
      `COD_K_SADDR:
      begin
        res_addr = sadr;
        res_mem = 1'b1;
        res_ck1 = op_imm ? `COD_CK_IMMS1 : `COD_CK_SHORT1;
        res_ck2 = op_imm ? `COD_CK_IMMS2 : (op_xch ? `COD_CK_SHORTX2 : `COD_CK_SHORT2);
        res_bytes = op_imm ? `COD_B3 : `COD_B2;
        res_legal = ~(op_imm & op_xch);
      end
      `COD_K_SFR:
      begin
        res_addr = sfra;
        res_mem = 1'b1;
        res_sfr = 1'b1;
        res_has_ck1 = 1'b0; // RQ15
        res_ck2 = op_imm ? `COD_CK_IMMS2 : (op_xch ? `COD_CK_SHORTX2 : `COD_CK_SHORT2);
        res_bytes = op_imm ? `COD_B3 : `COD_B2;
        res_legal = ~(op_imm & op_xch) &
                    ~((sfra >= `COD_SFR_HOLE_LO) & (sfra <= `COD_SFR_HOLE_HI)); // RQ6
      end
      `COD_K_ABS:
      begin
        res_addr = op_abs16; // RQ8
        res_mem = 1'b1;
        res_ck1 = `COD_CK_LONG1;
        res_ck2 = op_xch ? `COD_CK_LONGX2 : `COD_CK_LONG2;
        res_bytes = `COD_B3;
        res_legal = ~op_imm;
      end
      `COD_K_PSW:
      begin
        res_has_ck1 = 1'b0; // RQ15
        res_ck2 = op_imm ? `COD_CK_IMMS2 : `COD_CK_SHORT2;
        res_bytes = op_imm ? `COD_B3 : `COD_B2;
        res_legal = ~op_xch;
      end
      `COD_K_DE, `COD_K_HL:
      begin
        res_addr = (op_kind == `COD_K_DE) ? de_val : hl_val; // RQ21
        res_mem = 1'b1;
        res_ck1 = `COD_CK_SHORT1;
        res_ck2 = op_xch ? `COD_CK_SHORTX2 : `COD_CK_SHORT2;
        res_legal = ~op_imm;
      end
      `COD_K_HLBYTE:
      begin
        res_addr = hl_val + {8'h00, op_imm8}; // RQ21
        res_mem = 1'b1;
        res_ck1 = `COD_CK_LONG1; // RQ16
        res_ck2 = op_xch ? `COD_CK_LONGX2 : `COD_CK_LONG2;
        res_bytes = `COD_B2;
        res_legal = ~op_imm;
      end
      `COD_K_HLB, `COD_K_HLC:
      begin
        res_addr = hl_val + {8'h00, (op_kind == `COD_K_HLB) ? b_val : c_val}; // RQ21
        res_mem = 1'b1;
        res_ck1 = op_xch ? `COD_CK_LONG1 : `COD_CK_HLR1; // RQ17 RQ18
        res_ck2 = op_xch ? `COD_CK_LONGX2 : `COD_CK_HLR2;
        res_bytes = op_xch ? `COD_B2 : `COD_B1;
        res_legal = ~op_imm;
      end
      default:
        res_legal = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/cod_byte_move_unit.v */
// byte move and exchange execution unit with operand decode helpers
`default_nettype none
`include "cod_regs.vh"
// Notes on behaviour
// RQ1 - eight byte registers X A C B E D L H
// RQ2 - pairs AX BC DE HL are indices zero..three
// RQ3 - short direct spans FE20H-FF1FH, word form even
// RQ4 - call target resolves into 0800H-0FFFH
// RQ5 - table operand gives even address 0040H-007FH
// RQ6 - special register operands never reach FFD0H-FFDFH
// RQ7 - word special register needs capability, even address
// RQ8 - absolute address full range, even for words
// RQ9 - immediates are three, eight, sixteen bits wide
// RQ10 - displacement is signed byte added to counter
// RQ11 - four banks, chosen by bank select flags
// RQ12 - pair halves readable as upper, lower byte
// RQ13 - moves leave flags alone unless status written
// RQ14 - restore reloads flags from saved copy
// RQ15 - first count: fast RAM or no access
// RQ16 - A from HL plus byte: 8/9 clocks
// RQ17 - A from HL plus B: 6/7 clocks
// RQ18 - exchange A with HL plus C: 8/10
// RQ19 - instruction clock is one selected cpu clock
// RQ20 - second count for any other data area
// RQ21 - indirect forms use pair contents, pair unchanged
// RQ22 - exchange blocks interrupts between read and write
module cod_byte_move_unit #(
  parameter [15:0] HSRAM_LO = 16'hFB00,
  parameter [15:0] HSRAM_HI = 16'hFEFF
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // cpu clock selection, divide by two to the power of this
  input wire [2:0] cpu_clk_sel,
  // instruction request
  input wire ins_start,
  input wire op_xch,
  input wire op_dir,
  input wire op_imm,
  input wire [3:0] op_kind,
  input wire [2:0] op_reg,
  input wire [7:0] op_imm8,
  input wire [15:0] op_abs16,
  // instruction status
  output wire ins_busy,
  output reg ins_done,
  output reg ins_illegal,
  output reg [3:0] ins_clocks,
  output reg [1:0] ins_bytes,
  // data memory and special register space
  output reg [15:0] mem_addr,
  output wire mem_rd,
  output wire mem_wr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  // interrupt acceptance hold
  output wire int_block,
  // program status word
  output reg [7:0] psw_q,
  input wire flag_restore,
  input wire [7:0] flag_saved,
  // register observation
  input wire [2:0] rd_reg_idx,
  output reg [7:0] rd_reg_data,
  input wire [1:0] rd_pair_idx,
  output reg [7:0] rd_pair_hi,
  output reg [7:0] rd_pair_lo,
  // operand decode helpers
  input wire [7:0] chk_saddrp_off,
  output reg [15:0] chk_saddrp_addr,
  output reg chk_saddrp_ok,
  input wire [7:0] chk_sfrp_off,
  input wire chk_sfrp_capable,
  output reg chk_sfrp_ok,
  input wire [15:0] chk_abs16,
  input wire chk_abs_word,
  output reg chk_abs_ok,
  input wire [10:0] chk_call11,
  output reg [15:0] chk_call_addr,
  input wire [4:0] chk_table5,
  output reg [15:0] chk_table_addr,
  input wire [7:0] chk_disp8,
  input wire [15:0] chk_pc,
  output reg [15:0] chk_branch_pc,
  input wire [2:0] chk_bit3,
  output reg [7:0] chk_bit_mask,
  input wire [15:0] chk_word16,
  output reg [15:0] chk_word_q
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [7:0] rf [0:31];
  reg [1:0] state_q;
  reg [7:0] div_q;
  reg [3:0] tick_q;
  reg [3:0] total_q;
  reg xch_q;
  reg dir_q;
  reg imm_q;
  reg [3:0] kind_q;
  reg [2:0] reg_q;
  reg [7:0] imm8_q;
  reg need_rd_q;
  reg need_wr_q;
  reg rd_pend_q;
  reg [7:0] mdata_q;
  integer i;

  wire [1:0] bank;
  wire [7:0] div_lim;
  wire cpu_en;
  wire [4:0] a_idx;
  wire [4:0] r_idx;
  wire [7:0] a_val;
  wire [7:0] r_val;
  wire [15:0] hl_val;
  wire [15:0] de_val;
  wire [15:0] res_addr;
  wire res_mem;
  wire res_sfr;
  wire res_legal;
  wire res_has_ck1;
  wire [3:0] res_ck1;
  wire [3:0] res_ck2;
  wire [1:0] res_bytes;
  wire hsram_hit;
  wire use_ck1;
  wire accept;
  wire last_tick;
  wire [15:0] sfrp_addr;

  assign bank = {psw_q[`COD_PSW_RBS1], psw_q[`COD_PSW_RBS0]}; // RQ11
  assign a_idx = {bank, `COD_R_A}; // RQ1
  assign r_idx = {bank, op_reg};
  assign a_val = rf[a_idx];
  assign r_val = rf[r_idx];
  assign hl_val = {rf[{bank, `COD_R_H}], rf[{bank, `COD_R_L}]}; // RQ2
  assign de_val = {rf[{bank, `COD_R_D}], rf[{bank, `COD_R_E}]};

  // cpu clock enable from the selected division
  assign div_lim = (8'h01 << cpu_clk_sel) - 8'h01;
  // compare with >= so a lowered division never waits for the counter to wrap
  assign cpu_en = (div_q >= div_lim); // RQ19

  always @(posedge clk)
  begin
    if (!rst_n)
      div_q <= 8'h00;
    else if (cpu_en)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  cod_operand_resolve u_resolve (
    .op_xch(op_xch),
    .op_dir(op_dir),
    .op_imm(op_imm),
    .op_kind(op_kind),
    .op_reg(op_reg),
    .op_imm8(op_imm8),
    .op_abs16(op_abs16),
    .hl_val(hl_val),
    .de_val(de_val),
    .b_val(rf[{bank, `COD_R_B}]),
    .c_val(rf[{bank, `COD_R_C}]),
    .res_addr(res_addr),
    .res_mem(res_mem),
    .res_sfr(res_sfr),
    .res_legal(res_legal),
    .res_has_ck1(res_has_ck1),
    .res_ck1(res_ck1),
    .res_ck2(res_ck2),
    .res_bytes(res_bytes)
  );

  // clock column selection by target area
  assign hsram_hit = res_mem & ~res_sfr & (res_addr >= HSRAM_LO) & (res_addr <= HSRAM_HI);
  assign use_ck1 = res_has_ck1 & (~res_mem | hsram_hit); // RQ15 RQ20

  assign accept = ins_start & (state_q == ST_IDLE);
  assign ins_busy = (state_q == ST_RUN);
  assign last_tick = ins_busy & cpu_en & (tick_q == total_q - 4'h1);
  // read on the first instruction clock, write on the last
  assign mem_rd = ins_busy & cpu_en & (tick_q == 4'h0) & need_rd_q;
  assign mem_wr = last_tick & need_wr_q;
  // exchange holds interrupts across its read and write
  assign int_block = ins_busy & xch_q; // RQ22

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      tick_q <= 4'h0;
      total_q <= 4'h0;
      xch_q <= 1'b0;
      dir_q <= 1'b0;
      imm_q <= 1'b0;
      kind_q <= `COD_K_REG;
      reg_q <= `COD_R_X;
      imm8_q <= 8'h00;
      need_rd_q <= 1'b0;
      need_wr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      mdata_q <= 8'h00;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      ins_done <= 1'b0;
      ins_illegal <= 1'b0;
      ins_clocks <= 4'h0;
      ins_bytes <= 2'h0;
    end
    else
    begin
      ins_done <= 1'b0;
      ins_illegal <= 1'b0;
      rd_pend_q <= mem_rd;
      if (rd_pend_q)
        mdata_q <= mem_rdata;
      case (state_q)
        ST_IDLE:
        begin
          if (accept & ~res_legal)
            ins_illegal <= 1'b1; // RQ6
          else if (accept)
          begin
            state_q <= ST_RUN;
            tick_q <= 4'h0;
            total_q <= use_ck1 ? res_ck1 : res_ck2; // RQ15 RQ20
            ins_clocks <= use_ck1 ? res_ck1 : res_ck2;
            ins_bytes <= res_bytes;
            xch_q <= op_xch;
            dir_q <= op_dir;
            imm_q <= op_imm;
            kind_q <= op_kind;
            reg_q <= op_reg;
            imm8_q <= op_imm8;
            need_rd_q <= res_mem & ~op_imm & (~op_dir | op_xch);
            need_wr_q <= res_mem & (op_imm | op_dir | op_xch);
            mem_addr <= res_addr; // RQ21
            mem_wdata <= op_imm ? op_imm8 : a_val;
          end
        end
        ST_RUN:
        begin
          if (cpu_en)
            tick_q <= tick_q + 4'h1;
          if (last_tick)
          begin
            state_q <= ST_IDLE;
            ins_done <= 1'b1;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // register file and status word commit on the last instruction clock
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 32; i = i + 1)
        rf[i] <= 8'h00;
      psw_q <= `COD_PSW_RST;
    end
    else if (last_tick)
    begin
      case (kind_q)
        `COD_K_REG:
        begin
          if (imm_q)
            rf[{bank, reg_q}] <= imm8_q;
          else if (xch_q)
          begin
            rf[a_idx] <= rf[{bank, reg_q}];
            rf[{bank, reg_q}] <= a_val;
          end
          else if (dir_q)
            rf[{bank, reg_q}] <= a_val;
          else
            rf[a_idx] <= rf[{bank, reg_q}];
        end
        `COD_K_PSW:
        begin
          // only status writes touch Z, AC and CY
          if (imm_q)
            psw_q <= imm8_q; // RQ13
          else if (dir_q)
            psw_q <= a_val; // RQ13
          else
            rf[a_idx] <= psw_q;
        end
        default:
        begin
          if (need_rd_q)
            rf[a_idx] <= mdata_q; // RQ22
        end
      endcase
    end
    else if (flag_restore & ~ins_busy)
      psw_q <= flag_saved; // RQ14
  end

  // observation of registers and pair halves in the active bank
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_reg_data <= 8'h00;
      rd_pair_hi <= 8'h00;
      rd_pair_lo <= 8'h00;
    end
    else
    begin
      rd_reg_data <= rf[{bank, rd_reg_idx}]; // RQ1 RQ11
      rd_pair_hi <= rf[{bank, rd_pair_idx, 1'b1}]; // RQ2 RQ12
      rd_pair_lo <= rf[{bank, rd_pair_idx, 1'b0}]; // RQ12
    end
  end

  assign sfrp_addr = `COD_SFR_BASE | {8'h00, chk_sfrp_off};

  // operand decode helpers
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      chk_saddrp_addr <= 16'h0000;
      chk_saddrp_ok <= 1'b0;
      chk_sfrp_ok <= 1'b0;
      chk_abs_ok <= 1'b0;
      chk_call_addr <= 16'h0000;
      chk_table_addr <= 16'h0000;
      chk_branch_pc <= 16'h0000;
      chk_bit_mask <= 8'h00;
      chk_word_q <= 16'h0000;
    end
    else
    begin
      if (chk_saddrp_off < `COD_SADDR_WRAP)
        chk_saddrp_addr <= `COD_SADDR_HI_BASE | {8'h00, chk_saddrp_off}; // RQ3
      else
        chk_saddrp_addr <= `COD_SADDR_LO_BASE | {8'h00, chk_saddrp_off}; // RQ3
      chk_saddrp_ok <= ~chk_saddrp_off[0]; // RQ3
      chk_sfrp_ok <= chk_sfrp_capable & ~chk_sfrp_off[0] &
                     ~((sfrp_addr >= `COD_SFR_HOLE_LO) & (sfrp_addr <= `COD_SFR_HOLE_HI)); // RQ7 RQ6
      chk_abs_ok <= ~chk_abs_word | ~chk_abs16[0]; // RQ8
      chk_call_addr <= `COD_CALL11_BASE | {5'h00, chk_call11}; // RQ4
      chk_table_addr <= `COD_TABLE5_BASE | {10'h000, chk_table5, 1'b0}; // RQ5
      chk_branch_pc <= chk_pc + {{8{chk_disp8[7]}}, chk_disp8}; // RQ10
      chk_bit_mask <= 8'h01 << chk_bit3; // RQ9
      chk_word_q <= chk_word16; // RQ9
    end
  end
endmodule
`default_nettype wire

/* File: verification/cod_mem_model.sv */
// data memory and special register space model
`default_nettype none
module cod_mem_model (
  // clock
  input wire logic clk,
  // memory port
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  initial
  begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
    mem_rdata = 8'h00;
  end
  // data valid one cycle after a read, scrambled otherwise
  always @(posedge clk)
    if (mem_rd) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
  always @(posedge clk)
    if (mem_wr) mem[mem_addr] <= mem_wdata;
endmodule
`default_nettype wire

/* File: verification/cod_unit_chk_chk.sv */
// port assertions for the byte move unit
`default_nettype none
module cod_unit_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction side
  input wire logic [2:0] cpu_clk_sel,
  input wire logic ins_start,
  input wire logic ins_busy,
  input wire logic ins_done,
  input wire logic ins_illegal,
  input wire logic [3:0] ins_clocks,
  input wire logic mem_wr,
  input wire logic int_block,
  input wire logic [7:0] psw_q,
  input wire logic flag_restore,
  input wire logic [7:0] flag_saved,
  // decode helpers
  input wire logic [7:0] chk_saddrp_off,
  input wire logic [15:0] chk_saddrp_addr,
  input wire logic chk_saddrp_ok,
  input wire logic [7:0] chk_sfrp_off,
  input wire logic chk_sfrp_capable,
  input wire logic chk_sfrp_ok,
  input wire logic [10:0] chk_call11,
  input wire logic [15:0] chk_call_addr,
  input wire logic [4:0] chk_table5,
  input wire logic [15:0] chk_table_addr,
  input wire logic [7:0] chk_disp8,
  input wire logic [15:0] chk_pc,
  input wire logic [15:0] chk_branch_pc,
  input wire logic [2:0] chk_bit3,
  input wire logic [7:0] chk_bit_mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since the last accept
  logic [7:0] run_cnt_q;
  always_ff @(posedge clk)
    if (!rst_n) run_cnt_q <= 8'h00;
    else if (ins_start && !ins_busy) run_cnt_q <= 8'h00;
    else if (ins_busy) run_cnt_q <= run_cnt_q + 8'h01;
  run_length_a: assert property (ins_done && cpu_clk_sel == 3'h0 |->
    run_cnt_q == {4'h0, ins_clocks}) else $error("run length off");
  call_map_a: assert property ($past(rst_n) |->
    chk_call_addr == (16'h0800 | {5'h00, $past(chk_call11)})) else $error("call addr");
  table_map_a: assert property ($past(rst_n) |->
    chk_table_addr == (16'h0040 | {10'h000, $past(chk_table5), 1'b0})) else $error("table");
  branch_add_a: assert property ($past(rst_n) |-> chk_branch_pc ==
    $past(chk_pc) + {{8{$past(chk_disp8[7])}}, $past(chk_disp8)}) else $error("branch");
  bit_mask_a: assert property ($past(rst_n) |->
    chk_bit_mask == 8'h01 << $past(chk_bit3)) else $error("bit mask");
  saddr_map_a: assert property ($past(rst_n) |-> chk_saddrp_ok == !$past(chk_saddrp_off[0])
    && chk_saddrp_addr == (($past(chk_saddrp_off) < 8'h20) ? 16'hFF00 : 16'hFE00)
    + {8'h00, $past(chk_saddrp_off)}) else $error("short direct");
  sfr_hole_a: assert property ($past(rst_n) && $past(chk_sfrp_off[7:4]) == 4'hD
    |-> !chk_sfrp_ok) else $error("sfr hole");
  sfr_word_a: assert property ($past(rst_n) && chk_sfrp_ok |->
    $past(chk_sfrp_capable) && !$past(chk_sfrp_off[0])) else $error("sfr word");
  xch_hold_a: assert property (ins_busy && int_block |=>
    int_block || !ins_busy) else $error("exchange hold");
  psw_quiet_a: assert property ($past(rst_n) && $past(!ins_busy && !flag_restore)
    |-> $stable(psw_q)) else $error("psw changed");
  restore_load_a: assert property (flag_restore && !ins_busy |=>
    psw_q == $past(flag_saved)) else $error("restore");
  xch_run_c: cover property (int_block && mem_wr);
  refused_c: cover property (ins_illegal);
  slow_run_c: cover property (ins_done && cpu_clk_sel != 3'h0);
endmodule
`default_nettype wire

/* File: verification/cod_byte_move_unit_bench.sv */
// self-checking bench for the byte move unit
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module cod_byte_move_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, ins_start, op_xch, op_dir, op_imm, flag_restore, chk_sfrp_capable;
  logic chk_abs_word, ins_busy, ins_done, ins_illegal, mem_rd, mem_wr, int_block;
  logic chk_saddrp_ok, chk_sfrp_ok, chk_abs_ok;
  logic [1:0] rd_pair_idx, ins_bytes;
  logic [2:0] cpu_clk_sel, op_reg, rd_reg_idx, chk_bit3;
  logic [3:0] op_kind, ins_clocks;
  logic [4:0] chk_table5;
  logic [7:0] op_imm8, flag_saved, chk_saddrp_off, chk_sfrp_off, chk_disp8, mem_wdata;
  logic [7:0] mem_rdata, psw_q, rd_reg_data, rd_pair_hi, rd_pair_lo, chk_bit_mask, b, p;
  logic [10:0] chk_call11;
  logic [15:0] op_abs16, chk_abs16, chk_pc, chk_word16, mem_addr, chk_saddrp_addr;
  logic [15:0] chk_call_addr, chk_table_addr, chk_branch_pc, chk_word_q, hl;
  logic [95:0] rnd;
  logic [7:0] rf [0:7];
  logic [7:0] mm [logic [15:0]];
  logic [7:0] hv [0:1] = '{8'hFC, 8'h20};
  int fail_count, cmp_count, last_n, cycles;
  cod_byte_move_unit DUT (.*);
  cod_mem_model u_mem (.*);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] memv(input logic [15:0] a);
    return mm.exists(a) ? mm[a] : a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic run(input logic x, d, im, input logic [3:0] k, input logic [2:0] r,
      input logic [7:0] v, input logic [3:0] ck, input logic [1:0] by);
    @(posedge clk); #1
    {op_xch, op_dir, op_imm, op_kind, op_reg, op_imm8} = {x, d, im, k, r, v};
    ins_start = 1'b1;
    @(posedge clk); #1
    ins_start = 1'b0;
    last_n = 0;
    while (ins_done !== 1'b1 && ins_illegal !== 1'b1 && last_n < 300)
    begin
      if (ins_busy === 1'b1) `CHK("int_block", x, int_block)
      @(posedge clk); #1
      last_n++;
    end
    if (ck == 4'h0) `CHK("illegal", 1'b1, ins_illegal)
    else
    begin
      `CHK("clocks", ck, ins_clocks)
      `CHK("bytes", by, ins_bytes)
    end
  endtask
  task automatic chk_reg(input logic [2:0] i, input logic [7:0] e);
    @(posedge clk); #1
    rd_reg_idx = i;
    @(posedge clk); #1
    `CHK("reg", e, rd_reg_data)
  endtask
  task automatic mem_op(input logic x, input logic [3:0] k, input logic [7:0] v,
      input logic [3:0] ck, input logic [1:0] by, input logic [15:0] a);
    logic [7:0] t;
    t = rf[1];
    run(x, 1'b0, 1'b0, k, 3'h0, v, ck, by);
    `CHK("addr", a, mem_addr)
    rf[1] = memv(a);
    if (x) mm[a] = t;
    chk_reg(3'h1, rf[1]);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      complete_run;
    end
  end
  initial
  begin
    {ins_start, op_xch, op_dir, op_imm, flag_restore, chk_sfrp_capable, chk_abs_word,
     rd_pair_idx, cpu_clk_sel, op_reg, rd_reg_idx, chk_bit3, op_kind, chk_table5, op_imm8,
     flag_saved, chk_saddrp_off, chk_sfrp_off, chk_disp8, chk_call11, op_abs16, chk_abs16,
     chk_pc, chk_word16, rst_n} = '0;
    void'($urandom(2966));
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rf[i] = (i == 7) ? 8'hFC : 8'($urandom);
      run(1'b0, 1'b0, 1'b1, 4'h0, 3'(i), rf[i], 4'h4, 2'h2);
      chk_reg(3'(i), rf[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk); #1
      rd_pair_idx = 2'(i);
      @(posedge clk); #1
      `CHK("pair_hi", rf[2 * i + 1], rd_pair_hi)
      `CHK("pair_lo", rf[2 * i], rd_pair_lo)
    end
    run(1'b0, 1'b0, 1'b0, 4'h0, 3'h3, 8'h00, 4'h2, 2'h1);
    rf[1] = rf[3];
    chk_reg(3'h1, rf[1]);
    for (int j = 0; j < 2; j++)
    begin
      rf[7] = hv[j];
      run(1'b0, 1'b0, 1'b1, 4'h0, 3'h7, rf[7], 4'h4, 2'h2);
      hl = {rf[7], rf[6]};
      op_abs16 = hl;
      b = 8'($urandom);
      mem_op(1'b0, 4'h3, b, j ? 4'h9 : 4'h8, 2'h3, hl);
      mem_op(1'b0, 4'h7, b, j ? 4'h9 : 4'h8, 2'h2, hl + b);
      mem_op(1'b0, 4'h8, b, j ? 4'h7 : 4'h6, 2'h1, hl + rf[3]);
      mem_op(1'b1, 4'h9, b, j ? 4'hA : 4'h8, 2'h2, hl + rf[2]);
      mem_op(1'b0, 4'h9, b, j ? 4'h7 : 4'h6, 2'h1, hl + rf[2]);
      chk_reg(3'h6, rf[6]);
    end
    run(1'b0, 1'b0, 1'b0, 4'h2, 3'h0, 8'hD0, 4'h0, 2'h0);
    run(1'b0, 1'b1, 1'b0, 4'h2, 3'h0, 8'hDF, 4'h0, 2'h0);
    run(1'b0, 1'b1, 1'b0, 4'h0, 3'h1, 8'h00, 4'h0, 2'h0);
    `CHK("psw", 8'h00, psw_q)
    p = 8'($urandom) | 8'h28;
    run(1'b0, 1'b0, 1'b1, 4'h4, 3'h0, p, 4'h7, 2'h3);
    `CHK("psw", p, psw_q)
    chk_reg(3'h1, 8'h00);
    run(1'b0, 1'b1, 1'b0, 4'h4, 3'h0, 8'h00, 4'h5, 2'h2);
    `CHK("psw", 8'h00, psw_q)
    chk_reg(3'h1, rf[1]);
    @(posedge clk); #1
    flag_saved = 8'($urandom);
    flag_restore = 1'b1;
    @(posedge clk); #1
    flag_restore = 1'b0;
    `CHK("restore", flag_saved, psw_q)
    mem_op(1'b0, 4'h2, 8'h10, 4'h5, 2'h2, 16'hFF10);
    @(posedge clk); #1
    cpu_clk_sel = 3'h1;
    run(1'b0, 1'b0, 1'b1, 4'h0, 3'h3, 8'h11, 4'h4, 2'h2);
    `CHK("slow_len", 1'b1, last_n >= 7 && last_n <= 9)
    @(posedge clk); #1
    cpu_clk_sel = 3'h0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk); #1
      rnd = {$urandom, $urandom, $urandom};
      {chk_saddrp_off, chk_sfrp_off, chk_sfrp_capable, chk_abs16, chk_abs_word, chk_call11,
       chk_table5, chk_disp8, chk_pc, chk_bit3, chk_word16} = rnd[92:0];
      if (i < 2) {chk_sfrp_off, chk_saddrp_off} = i ? 16'hDF1F : 16'hD020;
      @(posedge clk); #1
      `CHK("abs_ok", !chk_abs_word || !chk_abs16[0], chk_abs_ok)
      `CHK("word", chk_word16, chk_word_q)
      `CHK("call", 16'h0800 | chk_call11, chk_call_addr)
      `CHK("table", 16'h0040 | {chk_table5, 1'b0}, chk_table_addr)
      `CHK("branch", chk_pc + {{8{chk_disp8[7]}}, chk_disp8}, chk_branch_pc)
      `CHK("bit_mask", 8'h01 << chk_bit3, chk_bit_mask)
      `CHK("saddr_ok", !chk_saddrp_off[0], chk_saddrp_ok)
      `CHK("saddr", ((chk_saddrp_off < 8'h20) ? 16'hFF00 : 16'hFE00) + chk_saddrp_off,
        chk_saddrp_addr)
      `CHK("sfr_ok", chk_sfrp_capable && !chk_sfrp_off[0] && chk_sfrp_off[7:4] != 4'hD,
        chk_sfrp_ok)
    end
    complete_run;
  end
endmodule
bind cod_byte_move_unit cod_unit_chk u_chk (.*);
`default_nettype wire
